// *** design/cdt_pkg.sv ***
// cdt_pkg: register map, field layout and reset values for the countdown timers
// assumes a 32-bit axi4-lite register bus and a 50 MHz system clock
package cdt_pkg;
	localparam int unsigned CDT_NUM_TIMERS = 3;
	localparam int unsigned CDT_ADDR_W     = 8;
	// byte offsets
	localparam logic [7:0]  CDT_OFS_TICK_DIV = 8'h04;
	localparam logic [7:0]  CDT_OFS_VALUE    = 8'h08;
	localparam logic [7:0]  CDT_OFS_RELOAD   = 8'h14;
	localparam logic [7:0]  CDT_OFS_CTRL     = 8'h20;
	localparam logic [7:0]  CDT_OFS_STRIDE   = 8'h04;
	// control field positions
	localparam int unsigned CDT_BIT_PRELOAD  = 0;
	localparam int unsigned CDT_BIT_RUN      = 1;
	localparam int unsigned CDT_BIT_SINGLE   = 2;
	// reset values
	localparam logic [17:0] CDT_TICK_DIV_RST = 18'h061A7;
	localparam logic [31:0] CDT_VALUE_RST    = 32'h0000_0000;
	localparam logic [31:0] CDT_RELOAD_RST   = 32'h0000_0000;
	localparam logic [2:0]  CDT_CTRL_RST     = 3'h0;
	// axi responses
	localparam logic [1:0]  CDT_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  CDT_RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic        single_fire_select;
		logic        countdown_run;
	} cdt_ctrl_t;
endpackage : cdt_pkg

// *** design/cdt_countdown_timer_control.sv ***
// cdt_countdown_timer_control: prescaler, per-timer down counters, axi4-lite registers
// assumes one synchronous clock; tick derived from clk standing in for the base clock
`timescale 1ns/100ps
module cdt_countdown_timer_control
	import cdt_pkg::*;
#(
	parameter int unsigned NUM_TIMERS = cdt_pkg::CDT_NUM_TIMERS
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	// axi4-lite write address and data
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// timer events
	output logic [NUM_TIMERS-1:0]      timer_irq
);
	import cdt_pkg::*;

	logic [17:0]     tick_div_r;
	logic [17:0]     presc_r;
	logic            tick_r;
	logic [31:0]     value_r  [NUM_TIMERS];
	logic [31:0]     reload_r [NUM_TIMERS];
	cdt_ctrl_t       ctrl_r   [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] irq_r;

	// write channel capture
	logic            aw_held_r;
	logic            w_held_r;
	logic [7:0]      awaddr_r;
	logic [31:0]     wdata_r;
	logic [3:0]      wstrb_r;
	logic            wr_go;
	logic            wr_hit;
	logic            rd_hit;
	logic [31:0]     rd_data;

	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	// decode helpers
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base, input int unsigned n);
		in_bank = (a[1:0] == 2'h0) && (a >= base) && (a < 8'(base + 8'(n * 4)));
	endfunction : in_bank

	function automatic int unsigned bank_idx(input logic [7:0] a, input logic [7:0] base);
		bank_idx = int'(8'(a - base) >> 2);
	endfunction : bank_idx

	always_comb begin
		wr_hit = 1'b0;
		if (awaddr_r == CDT_OFS_TICK_DIV) begin
			wr_hit = 1'b1;
		end else if (in_bank(awaddr_r, CDT_OFS_VALUE, NUM_TIMERS)) begin
			wr_hit = 1'b1;
		end else if (in_bank(awaddr_r, CDT_OFS_RELOAD, NUM_TIMERS)) begin
			wr_hit = 1'b1;
		end else if (in_bank(awaddr_r, CDT_OFS_CTRL, NUM_TIMERS)) begin
			wr_hit = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CDT_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? CDT_RESP_OKAY : CDT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// prescaler
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_div_r <= CDT_TICK_DIV_RST;
		end else if (wr_go && awaddr_r == CDT_OFS_TICK_DIV && wstrb_r[0]) begin
			tick_div_r <= wdata_r[17:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			presc_r <= 18'h00000;
			tick_r  <= 1'b0;
		end else if (presc_r >= tick_div_r) begin
			presc_r <= 18'h00000;
			tick_r  <= 1'b1;
		end else begin
			presc_r <= presc_r + 18'h00001;
			tick_r  <= 1'b0;
		end
	end

	// per-timer counters
	for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
		localparam logic [7:0] VAL_A = 8'(CDT_OFS_VALUE + 8'(g * 4));
		localparam logic [7:0] REL_A = 8'(CDT_OFS_RELOAD + 8'(g * 4));
		localparam logic [7:0] CTL_A = 8'(CDT_OFS_CTRL + 8'(g * 4));
		logic wr_val;
		logic wr_ctl;
		logic fire;
		logic preload;

		assign wr_val  = wr_go && awaddr_r == VAL_A && (&wstrb_r);
		assign wr_ctl  = wr_go && awaddr_r == CTL_A && wstrb_r[0];
		assign preload = wr_ctl && wdata_r[CDT_BIT_PRELOAD];
		assign fire    = tick_r && ctrl_r[g].countdown_run && value_r[g] == 32'h0000_0000;

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				reload_r[g] <= CDT_RELOAD_RST;
			end else if (wr_go && awaddr_r == REL_A && (&wstrb_r)) begin
				reload_r[g] <= wdata_r;
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				value_r[g] <= CDT_VALUE_RST;
			end else if (preload) begin
				value_r[g] <= reload_r[g];
			end else if (wr_val) begin
				value_r[g] <= wdata_r;
			end else if (fire && !ctrl_r[g].single_fire_select) begin
				value_r[g] <= reload_r[g];
			end else if (tick_r && ctrl_r[g].countdown_run && !fire) begin
				value_r[g] <= value_r[g] - 32'h0000_0001;
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				ctrl_r[g] <= cdt_ctrl_t'(CDT_CTRL_RST[CDT_BIT_SINGLE:CDT_BIT_RUN]);
			end else if (fire && ctrl_r[g].single_fire_select) begin
				ctrl_r[g].countdown_run <= 1'b0;
			end else if (wr_ctl) begin
				ctrl_r[g].countdown_run      <= wdata_r[CDT_BIT_RUN];
				ctrl_r[g].single_fire_select <= wdata_r[CDT_BIT_SINGLE];
			end
		end

		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				irq_r[g] <= 1'b0;
			end else begin
				irq_r[g] <= fire;
			end
		end
	end

	assign timer_irq = irq_r;

	// read channel
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		if (s_axi_araddr == CDT_OFS_TICK_DIV) begin
			rd_data = {14'h0000, tick_div_r};
		end else if (in_bank(s_axi_araddr, CDT_OFS_VALUE, NUM_TIMERS)) begin
			rd_data = value_r[bank_idx(s_axi_araddr, CDT_OFS_VALUE)];
		end else if (in_bank(s_axi_araddr, CDT_OFS_RELOAD, NUM_TIMERS)) begin
			rd_data = reload_r[bank_idx(s_axi_araddr, CDT_OFS_RELOAD)];
		end else if (in_bank(s_axi_araddr, CDT_OFS_CTRL, NUM_TIMERS)) begin
			rd_data = {29'h0000_0000, ctrl_r[bank_idx(s_axi_araddr, CDT_OFS_CTRL)], 1'b0};
		end else begin
			rd_hit  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CDT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_data;
			s_axi_rresp  <= rd_hit ? CDT_RESP_OKAY : CDT_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : cdt_countdown_timer_control

// *** dv/cdt_properties.sv ***
// cdt_properties: bus handshake and event checks on the timer unit ports
// assumes it is bound onto cdt_countdown_timer_control, one clock domain
`timescale 1ns/100ps
module cdt_properties
	import cdt_pkg::*;
#(
	parameter int unsigned NUM_TIMERS = CDT_NUM_TIMERS
) (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rst_b,
	// bus handshakes
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	// timer events
	input wire logic [NUM_TIMERS-1:0] timer_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	property p_wr_ans; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_drop: assert property (p_b_drop) else $error("bvalid kept after taken");
	property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_b_block: assert property (p_b_block) else $error("write accepted during response");
	property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_r_drop: assert property (p_r_drop) else $error("rvalid kept after taken");
	property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_r_block: assert property (p_r_block) else $error("read accepted during response");
	property p_irq_pulse; timer_irq != '0 |=> (timer_irq & $past(timer_irq)) == '0; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("event longer than a cycle");
	property p_rst_quiet;
		$rose(rst_b) |-> timer_irq == '0 && !s_axi_bvalid && !s_axi_rvalid && s_axi_awready && s_axi_arready;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
endmodule : cdt_properties

bind cdt_countdown_timer_control cdt_properties #(
	.NUM_TIMERS    (NUM_TIMERS)
) cdt_properties_i (
	.clk           (clk),
	.rst_b         (rst_b),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.timer_irq     (timer_irq)
);

// *** dv/tb.sv ***
// tb: random and directed register traffic for the countdown timers
// assumes the timer unit alone, inputs driven just after the rising edge
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
	import cdt_pkg::*;
	logic        clk = 1'h0, rst_b = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h3154, d, rl;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r, wr_rs;
	logic [2:0]  timer_irq;
	int          failures = 0, comparisons = 0, c;
	cdt_countdown_timer_control #(
		.NUM_TIMERS    (CDT_NUM_TIMERS)
	) cdt_countdown_timer_control_i (
		.clk           (clk),
		.rst_b         (rst_b),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.timer_irq     (timer_irq)
	);
	always #10 clk = ~clk;
	task automatic close_out();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic guard(input logic ok);
		if (!ok) begin
			failures++;
			close_out();
		end
	endtask : guard
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv);
		logic [2:0] p, t;
		int n;
		@(posedge clk);
		p = 3'h7;
		s_axi_awaddr <= a;
		s_axi_wdata <= dv;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
		for (n = 0; n < 50 && p != 3'h0; n++) begin
			@(negedge clk);
			t = p & {s_axi_awready, s_axi_wready, s_axi_bvalid};
			if (t[0])
				wr_rs = s_axi_bresp;
			@(posedge clk);
			p = p & ~t;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
		end
		guard(p == 3'h0);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
		logic [1:0] p, t;
		int n;
		@(posedge clk);
		p = 2'h3;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= p;
		for (n = 0; n < 50 && p != 2'h0; n++) begin
			@(negedge clk);
			t = p & {s_axi_arready, s_axi_rvalid};
			dv = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge clk);
			p = p & ~t;
			{s_axi_arvalid, s_axi_rready} <= p;
		end
		guard(p == 2'h0);
	endtask : axi_rd
	task automatic wait_irq(input int i, input int lim, input logic need);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (c < lim && timer_irq[i] !== 1'h1);
		if (need)
			guard(timer_irq[i] === 1'h1);
	endtask : wait_irq
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		axi_rd(CDT_OFS_CTRL, d, r);
		`CHK(d, 32'h0)
		axi_rd(CDT_OFS_TICK_DIV, d, r);
		`CHK(d[17:0], CDT_TICK_DIV_RST)
		axi_rd(8'hFC, d, r);
		`CHK(r, CDT_RESP_SLVERR)
		seed = lfsr(seed);
		axi_wr(CDT_OFS_VALUE + 8'h04, seed);
		`CHK(wr_rs, CDT_RESP_OKAY)
		axi_rd(CDT_OFS_VALUE + 8'h04, d, r);
		`CHK(d, seed)
		`CHK(r, CDT_RESP_OKAY)
		s_axi_wstrb <= 4'h1;
		axi_wr(CDT_OFS_VALUE + 8'h04, 32'h0);
		s_axi_wstrb <= 4'hF;
		`CHK(wr_rs, CDT_RESP_OKAY)
		axi_rd(CDT_OFS_VALUE + 8'h04, d, r);
		`CHK(d, seed)
		axi_wr(8'hFC, seed);
		`CHK(wr_rs, CDT_RESP_SLVERR)
		axi_wr(CDT_OFS_TICK_DIV, 32'h3);
		repeat (3) begin
			seed = lfsr(seed);
			rl = {28'h0, seed[3:0]} + 32'h2;
			axi_wr(CDT_OFS_RELOAD, rl);
			axi_rd(CDT_OFS_RELOAD, d, r);
			`CHK(d, rl)
			axi_wr(CDT_OFS_CTRL, 32'h3);
			axi_rd(CDT_OFS_VALUE, d, r);
			`CHK(rl - d <= 32'h1, 1'h1)
			axi_rd(CDT_OFS_CTRL, d, r);
			`CHK(d, 32'h2)
			wait_irq(0, 400, 1'h1);
			wait_irq(0, 400, 1'h1);
			`CHK(c, (rl + 32'h1) * 32'h4)
			axi_wr(CDT_OFS_CTRL, 32'h0);
		end
		axi_wr(CDT_OFS_RELOAD + 8'h08, 32'h2);
		axi_wr(CDT_OFS_CTRL + 8'h08, 32'h7);
		wait_irq(2, 400, 1'h1);
		`CHK(c < 400, 1'h1)
		axi_rd(CDT_OFS_CTRL + 8'h08, d, r);
		`CHK(d, 32'h4)
		axi_rd(CDT_OFS_VALUE + 8'h08, d, r);
		`CHK(d, 32'h0)
		wait_irq(2, 100, 1'h0);
		`CHK(c, 100)
		`CHK(timer_irq[2], 1'h0)
		axi_wr(CDT_OFS_CTRL, 32'h3);
		rst_b <= 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		axi_rd(CDT_OFS_CTRL, d, r);
		`CHK(d, 32'h0)
		axi_rd(CDT_OFS_VALUE, d, r);
		`CHK(d, CDT_VALUE_RST)
		axi_rd(CDT_OFS_TICK_DIV, d, r);
		`CHK(d[17:0], CDT_TICK_DIV_RST)
		close_out();
	end
endmodule : tb
